// [logic/stmc_ctrl.sv]
// Test mode control: development mode and forced normal mode gating
// Notes on behaviour
// RULE_01: Dev mode suppresses watchdog, timeout, start-up resets
// RULE_02: Trigger failure still records reset cause
// RULE_03: Standby and Sleep watchdog unaffected
// RULE_04: Dev mode blocks fail-safe except long undervoltage
// RULE_05: Start-up to restart still allowed
// RULE_06: Init bit accepted only in first start-up
// RULE_07: Test pin before battery enters dev mode
// RULE_08: Mode access with keep bit clear exits
// RULE_09: Keep bit written zero exits anytime
// RULE_10: No re-entry until new power-on
// RULE_11: Forced normal blocks all serial access; code gates only spi_grant, not mode or special register writes
// RULE_12: Forced normal disables watchdog and monitors
// RULE_13: Forced normal blocks fail-safe except undervoltage
// RULE_14: Long reset time, hold reset on undervoltage
// RULE_15: Transceiver and aux supplies kept on
// RULE_16: CAN held active, no off-line
// RULE_17: Inhibit outputs driven high
// RULE_18: Enable output follows reset output
// RULE_19: Test pin at battery connect forces normal
// RULE_20: Init bit clears on power-on only
// RULE_21: Power-on clears both mode flags
`timescale 1ns/1ps
module stmc_ctrl #(
	parameter int CLAMP_CYCLES = stmc_pkg::V1_CLAMP_CYC
) (
	// Clock and power-on reset
	input wire logic clk_sys,
	input wire logic reset,
	// Test pin level sampled at battery connection
	input wire logic test_pin_dev,
	input wire logic test_pin_forced,
	input wire logic first_startup,
	// Register accesses from the serial interface
	input wire logic mode_reg_wr,
	input wire logic dev_mode_keep_bit,
	input wire logic special_reg_wr,
	input wire logic dev_mode_init_bit,
	input wire logic spi_req,
	// Controller state and requests
	input wire stmc_pkg::stmc_mode_t mode,
	input wire stmc_pkg::stmc_rst_cause_t rst_cause,
	input wire stmc_pkg::stmc_trans_t trans_req,
	input wire logic mcu_supply_uv,
	input wire logic reset_out_n,
	input wire logic enable_norm,
	// Gated results
	output logic spi_grant,
	output logic sys_reset_req,
	output logic rst_cause_log,
	output logic failsafe_go,
	output logic restart_go,
	output logic wd_enable,
	output logic monitors_enable,
	output logic long_reset_sel,
	output logic hold_reset,
	output stmc_pkg::stmc_force_t force_out,
	// Status
	output logic dev_mode,
	output logic forced_mode,
	output logic dev_init_bit_q
);
	logic dev_reg, dev_next;
	logic forced_reg, forced_next;
	logic used_reg, used_next;
	logic init_reg, init_next;
	logic sampled_reg;
	logic uv_long;

	// Clamp time filter on the mcu supply undervoltage
	stmc_uv_timer #(.CYCLES(CLAMP_CYCLES)) u_uv (
		.clk_sys(clk_sys),
		.reset(reset),
		.uv_in(mcu_supply_uv),
		.expired(uv_long)
	);

	// Entry and exit decode
	wire logic pin_sample = first_startup && !sampled_reg;
	wire logic init_write = special_reg_wr && dev_mode_init_bit && first_startup
		&& (mode == stmc_pkg::STMC_STARTUP) && !used_reg; // RULE_06 RULE_10
	wire logic pin_enter = pin_sample && test_pin_dev && !used_reg; // RULE_07
	wire logic dev_exit = mode_reg_wr && !dev_mode_keep_bit; // RULE_08 RULE_09
	assign dev_next = dev_exit ? 1'b0 : (dev_reg || init_write || pin_enter);
	assign used_next = used_reg || (dev_reg && dev_exit); // RULE_10
	assign forced_next = forced_reg || (pin_sample && test_pin_forced); // RULE_19
	assign init_next = init_write ? 1'b1 : init_reg; // RULE_20

	// Mode flag registers, cleared by power-on; dev flag also cleared by a mode access with the keep bit clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dev_reg <= stmc_pkg::FLAG_POR; // RULE_21
			forced_reg <= stmc_pkg::FLAG_POR; // RULE_21
			used_reg <= 1'b0;
			init_reg <= stmc_pkg::DEV_INIT_POR; // RULE_20
			sampled_reg <= 1'b0;
		end else begin
			dev_reg <= dev_next;
			forced_reg <= forced_next;
			used_reg <= used_next;
			init_reg <= init_next;
			sampled_reg <= sampled_reg || first_startup;
		end
	end

	// Reset gating
	wire logic sleepish = (mode == stmc_pkg::STMC_STANDBY) || (mode == stmc_pkg::STMC_SLEEP);
	wire logic wd_cause = rst_cause.wd_overflow || rst_cause.wd_window_miss;
	wire logic soft_cause = wd_cause || rst_cause.int_timeout || rst_cause.startup_expired;
	wire logic suppress = (dev_reg && !sleepish) || forced_reg; // RULE_01 RULE_03 RULE_12
	assign sys_reset_req = rst_cause.other || (soft_cause && !suppress); // RULE_01
	assign rst_cause_log = soft_cause && !forced_reg; // RULE_02

	// Transition gating
	wire logic gated = dev_reg || forced_reg;
	assign failsafe_go = gated ? uv_long : trans_req.to_failsafe; // RULE_04 RULE_13 RULE_14
	assign restart_go = trans_req.to_restart && !forced_reg; // RULE_05

	// Forced normal effects
	assign spi_grant = spi_req && !forced_reg; // RULE_11
	assign wd_enable = !forced_reg; // RULE_12
	assign monitors_enable = !forced_reg; // RULE_12
	assign long_reset_sel = forced_reg; // RULE_14
	assign hold_reset = forced_reg && mcu_supply_uv; // RULE_14
	assign force_out.aux_on = forced_reg; // RULE_15
	assign force_out.transceiver_on = forced_reg; // RULE_15
	assign force_out.can_active = forced_reg; // RULE_16
	assign force_out.inhibit_limp_out = forced_reg; // RULE_17
	assign force_out.system_inhibit_out = forced_reg; // RULE_17
	assign force_out.enable_out = forced_reg ? reset_out_n : enable_norm; // RULE_18

	assign dev_mode = dev_reg;
	assign forced_mode = forced_reg;
	assign dev_init_bit_q = init_reg;

	// Assertions

	// Mode access with the keep bit clear ends dev mode
	a_dev_exit_clear: assert property (@(posedge clk_sys) disable iff (reset) // RULE_08
		mode_reg_wr && !dev_mode_keep_bit |=> !dev_mode)
		else $error("dev mode kept");

	// Mode access with the keep bit set keeps dev mode
	a_keep_stays: assert property (@(posedge clk_sys) disable iff (reset) // RULE_08
		dev_mode && mode_reg_wr && dev_mode_keep_bit |=> dev_mode)
		else $error("dev mode dropped");

	// Exit from dev mode is remembered
	a_used_set: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
		dev_mode && mode_reg_wr && !dev_mode_keep_bit |=> used_reg)
		else $error("exit not remembered");

	// The exit record lasts until power-on
	a_used_sticky: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
		used_reg |=> used_reg)
		else $error("exit record lost");

	// No rise of dev mode once it was left
	a_no_reentry: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
		used_reg |-> ##1 !$rose(dev_mode))
		else $error("dev mode reentered");

	// Idle dev mode stays off after exit
	a_no_reentry_idle: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
		used_reg && !dev_mode |=> !dev_mode)
		else $error("dev mode back after exit");

	// Dev mode only rises through an accepted entry
	a_dev_entry_src: assert property (@(posedge clk_sys) disable iff (reset) // RULE_06
		$rose(dev_mode) |-> $past(init_write || pin_enter))
		else $error("dev mode without entry");

	// Init bit outside start-up is refused
	a_init_refused: assert property (@(posedge clk_sys) disable iff (reset) // RULE_06
		special_reg_wr && (mode != stmc_pkg::STMC_STARTUP) && !dev_mode && !pin_enter
		|=> !dev_mode)
		else $error("init bit taken outside start-up");

	// Test pin level at first start-up enters dev mode
	a_pin_entry: assert property (@(posedge clk_sys) disable iff (reset) // RULE_07
		pin_enter && !dev_exit |=> dev_mode)
		else $error("pin entry missed");

	// No serial access granted in forced mode
	a_spi_blocked: assert property (@(posedge clk_sys) disable iff (reset) // RULE_11
		forced_mode |-> !spi_grant)
		else $error("spi in forced mode");

	// Watchdog overflow gives no reset in dev mode
	a_wd_reset_supp: assert property (@(posedge clk_sys) disable iff (reset) // RULE_01
		dev_mode && !forced_mode && !sleepish && rst_cause.wd_overflow && !rst_cause.other
		|-> !sys_reset_req && rst_cause_log)
		else $error("wd reset leaked");

	// Interrupt time-out gives no reset in dev mode
	a_int_timeout_supp: assert property (@(posedge clk_sys) disable iff (reset) // RULE_01
		dev_mode && !sleepish && rst_cause.int_timeout && !rst_cause.other |-> !sys_reset_req)
		else $error("time-out reset leaked");

	// Start-up expiry gives no reset in dev mode
	a_startup_supp: assert property (@(posedge clk_sys) disable iff (reset) // RULE_01
		dev_mode && !sleepish && rst_cause.startup_expired && !rst_cause.other
		|-> !sys_reset_req)
		else $error("start-up reset leaked");

	// Window miss still logs its cause
	a_cause_logged: assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
		dev_mode && !forced_mode && rst_cause.wd_window_miss |-> rst_cause_log)
		else $error("reset cause not logged");

	// Standby and Sleep watchdog resets unchanged
	a_sleep_unchanged: assert property (@(posedge clk_sys) disable iff (reset) // RULE_03
		dev_mode && !forced_mode && sleepish && rst_cause.wd_overflow |-> sys_reset_req)
		else $error("sleep wd changed");

	// Fail-safe blocked without undervoltage
	a_failsafe_block: assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
		(dev_mode || forced_mode) && !mcu_supply_uv |-> !failsafe_go)
		else $error("fail-safe not blocked");

	// Long undervoltage still reaches fail-safe in dev mode
	a_dev_uv_fs: assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
		dev_mode && uv_long |-> failsafe_go)
		else $error("dev mode blocked uv fail-safe");

	// Outside test modes the request passes
	a_normal_fs: assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
		!dev_mode && !forced_mode |-> failsafe_go == trans_req.to_failsafe)
		else $error("fail-safe request altered");

	// Start-up to restart stays possible
	a_restart_ok: assert property (@(posedge clk_sys) disable iff (reset) // RULE_05
		dev_mode && !forced_mode && trans_req.to_restart |-> restart_go)
		else $error("restart blocked");

	// Watchdog and monitors off in forced mode
	a_wd_off: assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
		forced_mode |-> !wd_enable && !monitors_enable)
		else $error("monitors active in forced mode");

	// Soft reset causes are ignored in forced mode
	a_forced_no_reset: assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
		forced_mode && !rst_cause.other |-> !sys_reset_req)
		else $error("soft reset in forced mode");

	// Forced mode fail-safe only after the clamp time
	a_forced_fs: assert property (@(posedge clk_sys) disable iff (reset) // RULE_13
		forced_mode && !uv_long |-> !failsafe_go)
		else $error("early fail-safe in forced mode");

	// Persisting undervoltage leads to fail-safe in bounded time
	a_uv_failsafe: assert property (@(posedge clk_sys) disable iff (reset) // RULE_13
		(forced_mode && mcu_supply_uv) [*2] |-> ##[0:1000] (failsafe_go || !mcu_supply_uv))
		else $error("no fail-safe on long undervoltage");

	// Long reset time chosen in forced mode
	a_long_reset: assert property (@(posedge clk_sys) disable iff (reset) // RULE_14
		forced_mode |-> long_reset_sel)
		else $error("short reset in forced mode");

	// Reset held while the supply is low
	a_hold_reset: assert property (@(posedge clk_sys) disable iff (reset) // RULE_14
		forced_mode && mcu_supply_uv |-> hold_reset)
		else $error("reset not held on undervoltage");

	// Undervoltage keeps forced mode
	a_uv_stays: assert property (@(posedge clk_sys) disable iff (reset) // RULE_14
		forced_mode && mcu_supply_uv |=> forced_mode)
		else $error("forced mode left on undervoltage");

	// Both supplies on in forced mode
	a_supplies_on: assert property (@(posedge clk_sys) disable iff (reset) // RULE_15
		forced_mode |-> force_out.aux_on && force_out.transceiver_on)
		else $error("supply off in forced mode");

	// Transceiver held active
	a_can_active: assert property (@(posedge clk_sys) disable iff (reset) // RULE_16
		forced_mode |-> force_out.can_active)
		else $error("transceiver not active");

	// Inhibit outputs high
	a_inhibit_high: assert property (@(posedge clk_sys) disable iff (reset) // RULE_17
		forced_mode |-> force_out.inhibit_limp_out && force_out.system_inhibit_out)
		else $error("inhibit outputs low");

	// Enable output mirrors the reset output
	a_enable_follow: assert property (@(posedge clk_sys) disable iff (reset) // RULE_18
		forced_mode |-> force_out.enable_out == reset_out_n)
		else $error("enable not following reset");

	// Forced mode entered from the pin sample
	a_forced_entry: assert property (@(posedge clk_sys) disable iff (reset) // RULE_19
		pin_sample && test_pin_forced |=> forced_mode)
		else $error("forced mode not entered");

	// Forced mode lasts until power-on
	a_forced_sticky: assert property (@(posedge clk_sys) disable iff (reset) // RULE_19
		forced_mode |=> forced_mode)
		else $error("forced mode lost");

	// Accepted init write sets the init bit
	a_init_bit_set: assert property (@(posedge clk_sys) disable iff (reset) // RULE_20
		init_write |=> dev_init_bit_q)
		else $error("init bit not set");

	// Init bit holds until power-on
	a_init_bit_kept: assert property (@(posedge clk_sys) disable iff (reset) // RULE_20
		dev_init_bit_q |=> dev_init_bit_q)
		else $error("init bit lost");

	// Power-on clears all flags
	a_reset_clears: assert property (@(posedge clk_sys) // RULE_21
		reset |=> !dev_mode && !forced_mode && !dev_init_bit_q)
		else $error("flags survive power-on");

	// Main scenarios
	c_dev_entry: cover property (@(posedge clk_sys) disable iff (reset) $rose(dev_mode));
	c_dev_exit: cover property (@(posedge clk_sys) disable iff (reset) $fell(dev_mode));
	c_forced: cover property (@(posedge clk_sys) disable iff (reset) $rose(forced_mode));
	c_uv_fs: cover property (@(posedge clk_sys) disable iff (reset) gated && failsafe_go);
	c_pin_dev: cover property (@(posedge clk_sys) disable iff (reset) pin_enter);
endmodule : stmc_ctrl

// [logic/stmc_pkg.sv]
// Package: shared types and constants for the test mode control block
package stmc_pkg;
	// Value of the init bit and mode flags after power-on
	localparam logic DEV_INIT_POR = 1'b0;
	localparam logic FLAG_POR = 1'b0;
	// Figures in ns, and cycles derived from the 10 ns clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int V1_CLAMP_TIME_NS = 1000;
	localparam int V1_CLAMP_CYC = (V1_CLAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	// Operating modes of the surrounding controller
	typedef enum logic [2:0] {
		STMC_STARTUP,
		STMC_RESTART,
		STMC_NORMAL,
		STMC_STANDBY,
		STMC_SLEEP,
		STMC_FAILSAFE
	} stmc_mode_t;

	// Reset request causes raised by the controller
	typedef struct packed {
		logic wd_overflow;
		logic wd_window_miss;
		logic int_timeout;
		logic startup_expired;
		logic other;
	} stmc_rst_cause_t;

	// Transition requests raised by the controller
	typedef struct packed {
		logic to_failsafe;
		logic to_restart;
		logic v1_undervolt;
	} stmc_trans_t;

	// Forced outputs while in forced normal mode
	typedef struct packed {
		logic aux_on;
		logic transceiver_on;
		logic can_active;
		logic inhibit_limp_out;
		logic system_inhibit_out;
		logic enable_out;
	} stmc_force_t;
endpackage : stmc_pkg

// [logic/stmc_uv_timer.sv]
// Undervoltage persistence timer for the mcu supply clamp time
`timescale 1ns/1ps
module stmc_uv_timer #(
	parameter int CYCLES = stmc_pkg::V1_CLAMP_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Condition and result
	input wire logic uv_in,
	output logic expired
);
	logic [stmc_pkg::CNT_W-1:0] cnt_reg;
	logic [stmc_pkg::CNT_W-1:0] cnt_next;
	localparam logic [stmc_pkg::CNT_W-1:0] END_CNT = CYCLES[stmc_pkg::CNT_W-1:0];
	wire logic at_end = (cnt_reg == END_CNT);

	// Count while low supply persists, hold at the end
	assign cnt_next = !uv_in ? '0 : (at_end ? cnt_reg : cnt_reg + 1'b1);

	// Counter register
	always_ff @(posedge clk_sys) begin
		if (reset)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign expired = at_end && uv_in;
endmodule : stmc_uv_timer

// [tb/stmc_host.sv]
// Host model: Mode register writes carrying the keep bit
`timescale 1ns/1ps
module stmc_host (
	// Request from the bench
	input wire logic trig,
	input wire logic keep,
	// Mode register write
	output logic mode_reg_wr,
	output logic dev_mode_keep_bit
);
	// Data line shows the inverse outside a write
	assign mode_reg_wr = trig;
	assign dev_mode_keep_bit = trig ? keep : ~keep;
endmodule : stmc_host

// [tb/tb_sbc_test_mode_control.sv]
// Testbench for the test mode control block
`timescale 1ns/1ps
module tb_sbc_test_mode_control;
	logic clk_sys = 1'b0, reset = 1'b1, pd = 1'b0, pf = 1'b0, fs = 1'b0, trig = 1'b0, keep = 1'b0;
	logic swr = 1'b0, ibit = 1'b0, spi_req = 1'b0, uv = 1'b0, rn = 1'b0, en = 1'b0, mwr, kb;
	stmc_pkg::stmc_mode_t mode = stmc_pkg::STMC_STARTUP;
	stmc_pkg::stmc_rst_cause_t rc = '0;
	stmc_pkg::stmc_trans_t tr = '0;
	stmc_pkg::stmc_force_t fo;
	logic sg, srr, rcl, fsg, rsg, wde, mone, lrs, hr, dm, fm, ibq;
	int mismatches = 0, tests_run = 0;
	stmc_ctrl #(.CLAMP_CYCLES(4)) i_dut (.clk_sys(clk_sys), .reset(reset),
		.test_pin_dev(pd), .test_pin_forced(pf), .first_startup(fs), .mode_reg_wr(mwr),
		.dev_mode_keep_bit(kb), .special_reg_wr(swr), .dev_mode_init_bit(ibit),
		.spi_req(spi_req), .mode(mode), .rst_cause(rc), .trans_req(tr), .mcu_supply_uv(uv),
		.reset_out_n(rn), .enable_norm(en), .spi_grant(sg), .sys_reset_req(srr),
		.rst_cause_log(rcl), .failsafe_go(fsg), .restart_go(rsg), .wd_enable(wde),
		.monitors_enable(mone), .long_reset_sel(lrs), .hold_reset(hr), .force_out(fo),
		.dev_mode(dm), .forced_mode(fm), .dev_init_bit_q(ibq));
	stmc_host i_host (.trig(trig), .keep(keep), .mode_reg_wr(mwr), .dev_mode_keep_bit(kb));
	// Clock at 100 MHz
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [5:0] e, input logic [5:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	// Power-on with test pin levels, then first start-up
	task automatic power_up(input logic d, input logic f);
		@(negedge clk_sys);
		{reset, pd, pf, fs} = {1'b1, d, f, 1'b0};
		mode = stmc_pkg::STMC_STARTUP;
		rc = '0;
		tr = '0;
		uv = 1'b0;
		cyc(3);
		chk(6'h0, {dm, fm, ibq});
		reset = 1'b0;
		fs = 1'b1;
		cyc(1);
	endtask : power_up
	task automatic mode_wr(input logic k);
		{trig, keep} = {1'b1, k};
		cyc(1);
		trig = 1'b0;
		cyc(1);
	endtask : mode_wr
	task automatic init_wr();
		{swr, ibit} = 2'b11;
		cyc(1);
		swr = 1'b0;
		cyc(1);
	endtask : init_wr
	task automatic t_dev_reg();
		power_up(1'b0, 1'b0);
		mode = stmc_pkg::STMC_NORMAL;
		init_wr();
		chk(6'h0, dm);
		mode = stmc_pkg::STMC_STARTUP;
		init_wr();
		chk(6'h3, {dm, ibq});
		tr.to_restart = 1'b1;
		cyc(1);
		chk(6'h1, rsg);
		{mode, tr} = {stmc_pkg::STMC_NORMAL, 3'b100};
		rc.wd_overflow = 1'b1;
		mode_wr(1'b1);
		chk(6'h5, {dm, srr, rcl});
		chk(6'h0, fsg);
		mode = stmc_pkg::STMC_STANDBY;
		cyc(1);
		chk(6'h3, {dm, srr});
		mode_wr(1'b0);
		chk(6'h1, {dm, srr});
		chk(6'h1, ibq);
		mode = stmc_pkg::STMC_STARTUP;
		init_wr();
		chk(6'h0, dm);
		$display("test dev_reg done");
	endtask : t_dev_reg
	task automatic t_dev_pin();
		power_up(1'b1, 1'b0);
		chk(6'h2, {dm, fm});
		mode_wr(1'b0);
		chk(6'h0, dm);
		power_up(1'b0, 1'b0);
		chk(6'h0, {dm, fm, ibq});
		$display("test dev_pin done");
	endtask : t_dev_pin
	task automatic t_forced();
		power_up(1'b0, 1'b1);
		{mode, spi_req, tr, rn} = {stmc_pkg::STMC_NORMAL, 1'b1, 3'b100, 1'b0};
		cyc(1);
		chk(6'h1, fm);
		chk(6'h1, {sg, wde, mone, fsg, lrs});
		chk(6'h3e, fo);
		rn = 1'b1;
		uv = 1'b1;
		cyc(3);
		chk(6'h3f, fo);
		chk(6'h2, {hr, fsg});
		cyc(1);
		chk(6'h7, {hr, fsg, fm});
		$display("test forced done");
	endtask : t_forced
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	// Watchdog against a hang
	initial begin
		#20000;
		mismatches++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		t_dev_reg();
		t_dev_pin();
		t_forced();
		report_and_stop();
	end
endmodule : tb_sbc_test_mode_control
